// ==== common/psc_consts.vh ====
// Constants for the power-save and peripheral clock controller.
// Assumes inclusion by bare name from the core design files.
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
`define PSC_SLEEP_SEL_BIT 4
`define PSC_DIV_LO_BIT 19
`define PSC_DIV_HI_BIT 20
`define PSC_DIV_1 2'h0
`define PSC_DIV_2 2'h1
`define PSC_DIV_4 2'h2
`define PSC_DIV_8 2'h3
`define PSC_PRIO_W 3
`define PSC_OSC_START_NS 1000
`define PSC_CLK_PERIOD_NS 20
`define PSC_OSC_START_CYC ((`PSC_OSC_START_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`endif

// ==== core/psc_pb_divider.v ====
// Peripheral bus clock enable generator with a glitch-free ratio change.
// Assumes the divisor code is stable on the system clock; changes apply at a period end, or at once while stopped.
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_pb_divider (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire run,
  input wire [1:0] div_code,
  // Divided clock tick
  output reg pb_tick
);
  reg [2:0] cnt_reg;
  reg [1:0] act_reg;
  reg [2:0] limit;
  always @* begin
    case (act_reg)
      `PSC_DIV_1: limit = 3'h0;
      `PSC_DIV_2: limit = 3'h1;
      `PSC_DIV_4: limit = 3'h3;
      default: limit = 3'h7;
    endcase
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
      act_reg <= `PSC_DIV_1;
      pb_tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 3'h0;
      pb_tick <= 1'b0;
      act_reg <= div_code;
    end else if (cnt_reg >= limit) begin
      // While running, a new ratio is taken only at a period boundary to avoid a runt pulse.
      cnt_reg <= 3'h0;
      pb_tick <= 1'b1;
      act_reg <= div_code;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      pb_tick <= 1'b0;
    end
  end
endmodule

// ==== core/psc_power_ctrl.v ====
// Power-save mode controller: run, idle and sleep states, wake logic,
// peripheral bus clock gating and peripheral read latency.
// Assumes CPU, interrupt controller and watchdog signals are on clk.
// Assumes irq_pending is already masked by the interrupt enables.
// Assumes osc_was_stopped is settled before a wake event arrives.
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_power_ctrl #(
  parameter NUM_PERIPH = 8,
  parameter OSC_START_CYC = `PSC_OSC_START_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Oscillator control and source state
  input wire [31:0] oscillator_control_reg,
  input wire osc_was_stopped,
  // CPU side
  input wire wait_exec,
  input wire [`PSC_PRIO_W-1:0] cpu_prio,
  input wire periph_rd_req,
  output wire periph_rd_done,
  output wire cpu_halt,
  // Interrupt controller and watchdog
  input wire irq_pending,
  input wire irq_sleep_capable,
  input wire [`PSC_PRIO_W-1:0] irq_prio,
  input wire watchdog_timer_timeout,
  input wire dev_reset_event,
  // Clock outputs and per-peripheral halt-in-idle requests
  output wire system_core_clock_en,
  output wire core_fabric_clk_en,
  output wire peripheral_bus_clock_tick,
  input wire [NUM_PERIPH-1:0] halt_in_idle,
  output wire [NUM_PERIPH-1:0] periph_clk_en,
  // Status
  output wire in_idle,
  output wire in_sleep
);
  localparam ST_RUN = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_SLEEP = 2'h2;
  localparam ST_START = 2'h3;
  localparam CW = 16;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CW-1:0] start_cnt_reg;
  reg [CW-1:0] start_cnt_next;
  reg rd_wait_reg;
  wire sleep_sel;
  wire [1:0] periph_clock_divisor;
  wire hi_prio;
  wire force_wake;
  wire pb_run;
  wire pb_tick;
  // Wake decode and next-state decode feeding the registered outputs.
  wire wake_any_sleep;
  wire sleep_to_idle;
  wire need_startup;
  wire start_done;
  wire run_next;
  wire idle_next;
  wire sleep_next;
  wire clk_on_next;
  reg idle_reg;
  reg sleep_reg;
  reg halt_reg;
  reg clk_on_reg;

  assign sleep_sel = oscillator_control_reg[`PSC_SLEEP_SEL_BIT];
  assign periph_clock_divisor = oscillator_control_reg[`PSC_DIV_HI_BIT:`PSC_DIV_LO_BIT];
  // The priority compare is strict: an equal priority never wakes the CPU.
  assign hi_prio = irq_pending && (irq_prio > cpu_prio);
  // Reset and watchdog events wake regardless of priority.
  assign force_wake = dev_reset_event || watchdog_timer_timeout;
  // Sleep keeps only sleep-capable sources alive, so only they, a device reset or a watchdog timeout can end it.
  assign wake_any_sleep = force_wake || (hi_prio && irq_sleep_capable);
  // A pending low-priority source restarts the clocks but keeps the CPU halted.
  assign sleep_to_idle = irq_pending && irq_sleep_capable;
  // A device reset restarts the source itself, so no start-up wait is added.
  assign need_startup = osc_was_stopped && !dev_reset_event;
  assign start_done = (start_cnt_reg <= {{(CW-1){1'b0}}, 1'b1});

  always @* begin
    state_next = state_reg;
    start_cnt_next = start_cnt_reg;
    case (state_reg)
      ST_RUN: begin
        // A wait in run picks sleep or idle from the select bit.
        if (wait_exec && sleep_sel) begin
          state_next = ST_SLEEP;
        end else if (wait_exec) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // A low-priority interrupt leaves the CPU halted here.
        if (force_wake || hi_prio) begin
          state_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_any_sleep) begin
          if (need_startup) begin
            state_next = ST_START;
            start_cnt_next = OSC_START_CYC[CW-1:0];
          end else begin
            state_next = ST_RUN;
          end
        end else if (sleep_to_idle) begin
          state_next = ST_IDLE;
        end
      end
      ST_START: begin
        // The CPU stays halted and the clocks stay off until the count runs out or a device reset arrives.
        if (dev_reset_event) begin
          state_next = ST_RUN;
          start_cnt_next = {CW{1'b0}};
        end else if (start_done) begin
          state_next = ST_RUN;
          start_cnt_next = {CW{1'b0}};
        end else begin
          start_cnt_next = start_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        // All four codes are used; any unknown value recovers to run.
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      start_cnt_reg <= {CW{1'b0}};
    end else begin
      state_reg <= state_next;
      start_cnt_reg <= start_cnt_next;
    end
  end

  // Decode of the next state, so that registered outputs change with the state.
  assign run_next = (state_next == ST_RUN);
  assign idle_next = (state_next == ST_IDLE);
  assign sleep_next = (state_next == ST_SLEEP);
  // The system clock source is stopped only in sleep and during start-up.
  assign clk_on_next = run_next || idle_next;

  // Status, system core and fabric clock enables come from flip-flops to keep them free of decode glitches.
  always @(posedge clk) begin
    if (!rst_n) begin
      idle_reg <= 1'h0;
      sleep_reg <= 1'h0;
      halt_reg <= 1'h0;
      clk_on_reg <= 1'h1;
    end else begin
      idle_reg <= idle_next;
      sleep_reg <= sleep_next;
      halt_reg <= !run_next;
      clk_on_reg <= clk_on_next;
    end
  end

  assign in_idle = idle_reg;
  assign in_sleep = sleep_reg;
  assign cpu_halt = halt_reg;
  assign system_core_clock_en = clk_on_reg;
  assign core_fabric_clk_en = clk_on_reg;
  // The divider looks one state ahead, so no tick is issued in the first sleep cycle.
  assign pb_run = clk_on_next;

  // The divider keeps its own count; a ratio change waits for its period end unless the divider is stopped.
  psc_pb_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(pb_run),
    .div_code(periph_clock_divisor),
    .pb_tick(pb_tick)
  );

  assign peripheral_bus_clock_tick = pb_tick;

  // Each peripheral enable follows the tick unless it asked to halt in idle.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi = gi + 1) begin : g_pclk
      assign periph_clk_en[gi] = pb_tick && !(in_idle && halt_in_idle[gi]);
    end
  endgenerate

  // Read completes on the next peripheral tick after the request.
  // A request that meets a tick finishes at once; otherwise it is held here
  // until the divider's next tick, which is up to seven cycles away at 1:8.
  always @(posedge clk) begin
    if (!rst_n) begin
      rd_wait_reg <= 1'b0;
    end else if (pb_tick) begin
      rd_wait_reg <= 1'b0;
    end else if (periph_rd_req) begin
      rd_wait_reg <= 1'b1;
    end
  end
  assign periph_rd_done = (rd_wait_reg || periph_rd_req) && pb_tick;
endmodule

// ==== testbench/psc_cpu_model.sv ====
// CPU side model that issues one peripheral read per go pulse.
// Assumes done is combinational and sampled on the rising edge.
`timescale 1ns/1ps
module psc_cpu_model (
  // Clock
  input wire clk,
  // Read handshake
  input wire go,
  input wire done,
  output logic req
);
  initial req = 1'b0;
  always @(posedge clk) begin
    if (req && done) begin
      req <= 1'b0;
    end else if (go) begin
      req <= 1'b1;
    end
  end
endmodule

// ==== testbench/psc_power_ctrl_assertions.sv ====
// Checker on the ports of the power-save controller.
// Assumes it is bound to psc_power_ctrl on one clock.
`timescale 1ns/1ps
`include "psc_consts.vh"
module psc_power_ctrl_assertions #(
  parameter NUM_PERIPH = 8
) (
  // Clock, reset and control
  input wire clk,
  input wire rst_n,
  input wire [31:0] oscillator_control_reg,
  input wire osc_was_stopped,
  input wire wait_exec,
  input wire [`PSC_PRIO_W-1:0] cpu_prio,
  input wire [`PSC_PRIO_W-1:0] irq_prio,
  input wire irq_pending,
  input wire irq_sleep_capable,
  input wire watchdog_timer_timeout,
  input wire dev_reset_event,
  input wire periph_rd_req,
  input wire [NUM_PERIPH-1:0] halt_in_idle,
  // Observed outputs
  input wire periph_rd_done,
  input wire cpu_halt,
  input wire system_core_clock_en,
  input wire core_fabric_clk_en,
  input wire peripheral_bus_clock_tick,
  input wire [NUM_PERIPH-1:0] periph_clk_en,
  input wire in_idle,
  input wire in_sleep
);
  wire calm = !watchdog_timer_timeout && !dev_reset_event;
  wire hi = irq_pending && irq_prio > cpu_prio;
  wire lo = irq_pending && irq_prio <= cpu_prio && calm;
  wire [NUM_PERIPH-1:0] gate = {NUM_PERIPH{peripheral_bus_clock_tick}};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait;
    !cpu_halt && wait_exec && calm && !irq_pending;
  endsequence
  chk_wait_idle: assert property (s_wait ##0 !oscillator_control_reg[4] |=> in_idle)
    else $error("wait did not enter idle");
  chk_wait_sleep: assert property (s_wait ##0 oscillator_control_reg[4] |=> in_sleep)
    else $error("wait did not enter sleep");
  chk_sleep_stop: assert property (in_sleep |-> !system_core_clock_en && !peripheral_bus_clock_tick)
    else $error("clocks run in sleep");
  chk_idle_halt: assert property (in_idle |-> cpu_halt && system_core_clock_en)
    else $error("idle state wrong");
  chk_sleep_wake: assert property (in_sleep && hi && irq_sleep_capable && !osc_was_stopped |=> !cpu_halt)
    else $error("sleep not woken");
  chk_sleep_idle: assert property (in_sleep && lo && irq_sleep_capable |=> in_idle)
    else $error("sleep not moved to idle");
  chk_idle_wake: assert property (in_idle && hi |=> !cpu_halt)
    else $error("idle not woken");
  chk_idle_stay: assert property (in_idle && lo |=> in_idle)
    else $error("idle left on low priority");
  chk_event_exit: assert property ((in_idle || in_sleep) && !calm && !osc_was_stopped |=> !cpu_halt)
    else $error("event did not wake");
  chk_read_tick: assert property (periph_rd_done |-> peripheral_bus_clock_tick)
    else $error("read done off tick");
  chk_idle_gate: assert property (periph_clk_en == (gate & ~({NUM_PERIPH{in_idle}} & halt_in_idle)))
    else $error("peripheral enable wrong");
  chk_read_now: assert property (!cpu_halt && periph_rd_req && peripheral_bus_clock_tick
    |-> periph_rd_done) else $error("read not finished on tick");
  chk_fabric_on: assert property ((in_idle || !cpu_halt) |-> core_fabric_clk_en)
    else $error("fabric clock stopped");
  chk_sleep_hold: assert property (in_sleep && calm && !irq_sleep_capable |=> in_sleep)
    else $error("sleep left on stopped source");
endmodule
bind psc_power_ctrl psc_power_ctrl_assertions #(.NUM_PERIPH(NUM_PERIPH)) psc_chk (
  .clk(clk),
  .rst_n(rst_n),
  .oscillator_control_reg(oscillator_control_reg),
  .osc_was_stopped(osc_was_stopped),
  .wait_exec(wait_exec),
  .cpu_prio(cpu_prio),
  .irq_prio(irq_prio),
  .irq_pending(irq_pending),
  .irq_sleep_capable(irq_sleep_capable),
  .watchdog_timer_timeout(watchdog_timer_timeout),
  .dev_reset_event(dev_reset_event),
  .periph_rd_req(periph_rd_req),
  .halt_in_idle(halt_in_idle),
  .periph_rd_done(periph_rd_done),
  .cpu_halt(cpu_halt),
  .system_core_clock_en(system_core_clock_en),
  .core_fabric_clk_en(core_fabric_clk_en),
  .peripheral_bus_clock_tick(peripheral_bus_clock_tick),
  .periph_clk_en(periph_clk_en),
  .in_idle(in_idle),
  .in_sleep(in_sleep)
);

// ==== testbench/psc_testbench.sv ====
// Self-checking bench for the power-save controller.
// Assumes a 50 MHz clock and a start-up count of 3.
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_n = 0, ose = 0, we = 0, irq = 0, cap = 1, wdt = 0, rev = 0, go = 0;
  logic [31:0] osc = 0;
  logic [2:0] cp = 3'h3, ip = 3'h0;
  logic [7:0] hid = 8'h5A, pce;
  logic rq, done, halt, sce, cfe, tick, idl, slp;
  int fails = 0, n_compared = 0, n;
  always #10 clk = ~clk;
  psc_power_ctrl #(.OSC_START_CYC(3)) psc_power_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .oscillator_control_reg(osc), .osc_was_stopped(ose), .wait_exec(we), .cpu_prio(cp),
    .periph_rd_req(rq), .periph_rd_done(done), .cpu_halt(halt), .irq_pending(irq),
    .irq_sleep_capable(cap), .irq_prio(ip), .watchdog_timer_timeout(wdt),
    .dev_reset_event(rev), .system_core_clock_en(sce), .core_fabric_clk_en(cfe),
    .peripheral_bus_clock_tick(tick), .halt_in_idle(hid), .periph_clk_en(pce),
    .in_idle(idl), .in_sleep(slp));
  psc_cpu_model psc_cpu_model_inst (.clk(clk), .go(go), .done(done), .req(rq));
  task step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Waits for the next divided tick and leaves its spacing in n.
  task wt;
    n = 0;
    do begin
      step();
      n++;
    end while (tick !== 1'b1 && n < 20);
    if (tick !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  task t_div;
    for (int c = 0; c < 4; c++) begin
      osc[20:19] = c[1:0];
      wt();
      wt();
      wt();
      chk("period", n[7:0], 8'h1 << c);
      chk("fabric", cfe, 8'h1);
    end
  endtask
  task t_read(input logic [1:0] c);
    osc = {11'h0, c, 19'h0};
    wt();
    go = 1;
    step();
    go = 0;
    n = 0;
    while (rq === 1'b1 && n < 20) begin
      step();
      n++;
    end
    if (rq === 1'b1) begin
      fails++;
      report_and_stop();
    end
    chk("read", (c == 2'h0) ? (n == 1) : (n >= 1 && n <= 8), 8'h1);
  endtask
  task t_idle;
    osc = 32'h0;
    we = 1;
    step();
    we = 0;
    chk("idle", {idl, halt, sce, slp}, 8'hE);
    {irq, ip} = 4'hB;
    step();
    chk("idle low", idl, 8'h1);
    wt();
    chk("gate", pce, 8'hA5);
    ip = 3'h4;
    step();
    irq = 0;
    chk("idle wake", halt, 8'h0);
  endtask
  task t_sleep(input logic stp);
    osc = 32'h10;
    we = 1;
    step();
    we = 0;
    chk("sleep", {slp, sce, tick}, 8'h4);
    {cap, irq, ip} = 5'h0F;
    step();
    chk("sleep hold", slp, 8'h1);
    {cap, irq, ip} = 5'h1A;
    step();
    irq = 0;
    chk("to idle", {idl, halt}, 8'h3);
    wdt = 1;
    step();
    wdt = 0;
    chk("wdt idle", halt, 8'h0);
    we = 1;
    step();
    {we, rev} = 2'h1;
    step();
    rev = 0;
    chk("rst sleep", halt, 8'h0);
    we = 1;
    step();
    {we, ose, irq, ip} = {1'h0, stp, 1'h1, 3'h5};
    step();
    {ose, irq} = 2'h0;
    n = 0;
    while (halt !== 1'b0 && n < 20) begin
      step();
      n++;
    end
    if (halt !== 1'b0) begin
      fails++;
      report_and_stop();
    end
    chk("wake", n[7:0], stp ? 8'h3 : 8'h0);
  endtask
  initial begin
    step(20);
    rst_n = 1;
    step();
    t_div();
    t_read(2'h0);
    t_read(2'h3);
    t_idle();
    t_sleep(1'b0);
    t_sleep(1'b1);
    report_and_stop();
  end
endmodule
